//--- hw/ovh_fifo.sv
// synchronous valid/ready fifo for the extraction byte stream
`timescale 1ns/1ns
`default_nettype none
module ovh_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  assign full        = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty       = (wr_ptr_r == rd_ptr_r);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign push        = in_valid_i & ~full;
  assign pop         = out_ready_i & ~empty;
  assign out_data_o  = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- hw/ovh_port_pkg.sv
// shared constants and types for the serial overhead access port
package ovh_port_pkg;
  localparam int          BYTE_W        = 8;
  localparam logic [2:0]  BIT_FIRST     = 3'h0;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam logic [2:0]  BIT_STEP      = 3'h1;
  localparam int          FIFO_DEPTH    = 8;
  localparam int          SOH_BYTES_DEF = 27;
  localparam int          POH_BYTES_DEF = 9;
  localparam int          GAP_BITS_DEF  = 16;
  localparam logic [7:0]  CNT_ZERO      = 8'h00;
  localparam logic [7:0]  CNT_STEP      = 8'h01;
  // extraction word: first-bit mark, path mark, overhead byte
  localparam int          RXW_W         = 10;
  localparam int          RXW_FIRST     = 9;
  localparam int          RXW_PATH      = 8;
  // insertion word: first mark, path mark, mask byte, data byte
  localparam int          TXW_W         = 18;
  localparam int          TXW_FIRST     = 17;
  localparam int          TXW_PATH      = 16;
  localparam int          TXW_MASK_LO   = 8;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b01,
    RX_SHIFT = 2'b10
  } rx_state_t;

  typedef enum logic [2:0] {
    TX_SOH = 3'b001,
    TX_POH = 3'b010,
    TX_GAP = 3'b100
  } tx_state_t;
endpackage

//--- hw/ovh_serial_port.sv
// serial section/path overhead extraction and insertion port
// Summary of operation
// [RULE1] every extraction output, serial data included, changes on the falling link clock edge.
// [RULE2] the far end samples the serial extraction data on the rising link clock edge.
// [RULE3] the extraction frame pulse is high for one clock at the first bit of A1 and of J1 only.
// [RULE4] during the extraction frame pulse a low path flag means A1 and a high one means J1.
// [RULE5] extraction valid is high only while overhead bits are being shifted out.
// [RULE6] while extraction valid is high the path flag tells section from path overhead.
// [RULE7] the extraction path flag is high for path overhead, low for section, on falling edges.
// [RULE8] the insertion window enable is high exactly while overhead may be inserted.
// [RULE9] the far end presents replacement bits on the serial input while raising insert.
// [RULE10] insertion data, insert request and input path flag are sampled on rising edges.
// [RULE11] the insertion frame pulse is high one clock at the first bit of A1 and of J1.
// [RULE12] during the insertion frame pulse a low path flag means A1, a high one J1.
// [RULE13] the far end raises insert in line with exactly the bits it replaces.
// [RULE14] the insertion path flag is high for path, low for section, changed on falling edges.
// [RULE15] the insertion path flag may be turned to an input, then sampled on rising edges.
// [RULE16] any bit sampled with insert low carries the internally generated overhead value.
// [RULE17] overhead bytes travel most significant bit first in both directions.
`timescale 1ns/1ns
`default_nettype none
module ovh_serial_port
  import ovh_port_pkg::*;
#(
  parameter int SOH_BYTES = ovh_port_pkg::SOH_BYTES_DEF,
  parameter int POH_BYTES = ovh_port_pkg::POH_BYTES_DEF,
  parameter int GAP_BITS  = ovh_port_pkg::GAP_BITS_DEF
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    ovh_clk_i,
  // extraction source
  input  wire logic [ovh_port_pkg::BYTE_W-1:0] rx_byte_i,
  input  wire logic                    rx_byte_path_i,
  input  wire logic                    rx_byte_first_i,
  input  wire logic                    rx_byte_valid_i,
  output logic                         rx_byte_ready_o,
  // extraction pins
  output logic                         rx_ovh_clk_out_o,
  output logic                         rx_ovh_serial_out_o,
  output logic                         rx_ovh_frame_pulse_o,
  output logic                         rx_ovh_valid_flag_o,
  output logic                         rx_path_ovh_flag_o,
  // insertion control and result
  input  wire logic                    tx_enable_i,
  input  wire logic                    tx_path_dir_in_i,
  input  wire logic [ovh_port_pkg::BYTE_W-1:0] tx_default_byte_i,
  output logic      [ovh_port_pkg::BYTE_W-1:0] tx_byte_o,
  output logic      [ovh_port_pkg::BYTE_W-1:0] tx_byte_mask_o,
  output logic                         tx_byte_path_o,
  output logic                         tx_byte_first_o,
  output logic                         tx_byte_valid_o,
  // insertion pins
  output logic                         tx_ovh_clk_out_o,
  output logic                         tx_ovh_window_enable_o,
  input  wire logic                    tx_ovh_serial_in_i,
  input  wire logic                    tx_ovh_insert_req_i,
  output logic                         tx_ovh_frame_pulse_o,
  input  wire logic                    tx_path_ovh_flag_i,
  output logic                         tx_path_ovh_flag_o,
  output logic                         tx_path_ovh_flag_oe_o
);
  import ovh_port_pkg::*;

  localparam logic [7:0] SOH_LAST = 8'(SOH_BYTES - 1);
  localparam logic [7:0] POH_LAST = 8'(POH_BYTES - 1);
  localparam logic [7:0] GAP_LAST = 8'(GAP_BITS - 1);

  // ---------------- reference domain: fifo and extraction handshake
  logic [RXW_W-1:0] fifo_in;
  logic [RXW_W-1:0] fifo_out;
  logic             fifo_out_valid;
  logic             fifo_pop;
  logic [RXW_W-1:0] rx_hold_r;
  logic             rx_req_tgl_r;
  logic             rx_busy_r;
  logic             rx_ack_s1_r;
  logic             rx_ack_s2_r;
  logic             rx_ack_last_r;
  logic             rx_ack_seen;
  logic             rx_ack_tgl_r;

  assign fifo_in     = {rx_byte_first_i, rx_byte_path_i, rx_byte_i};
  assign fifo_pop    = fifo_out_valid & ~rx_busy_r;
  assign rx_ack_seen = rx_ack_s2_r ^ rx_ack_last_r;

  ovh_fifo #(
    .WIDTH (RXW_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (ref_clk_i),
    .reset_i     (reset_i),
    .in_data_i   (fifo_in),
    .in_valid_i  (rx_byte_valid_i),
    .in_ready_o  (rx_byte_ready_o),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (~rx_busy_r)
  );

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx_hold_r     <= '0;
      rx_req_tgl_r  <= 1'b0;
      rx_busy_r     <= 1'b0;
      rx_ack_s1_r   <= 1'b0;
      rx_ack_s2_r   <= 1'b0;
      rx_ack_last_r <= 1'b0;
    end else begin
      rx_ack_s1_r   <= rx_ack_tgl_r;
      rx_ack_s2_r   <= rx_ack_s1_r;
      rx_ack_last_r <= rx_ack_s2_r;
      if (fifo_pop) begin
        rx_hold_r    <= fifo_out;
        rx_req_tgl_r <= ~rx_req_tgl_r;
        rx_busy_r    <= 1'b1;
      end else if (rx_ack_seen) begin
        rx_busy_r <= 1'b0;
      end
    end
  end

  // ---------------- link domain reset and level crossings
  logic link_rst_s1_r;
  logic link_rst_r;
  logic en_s1_r;
  logic en_s2_r;
  logic dir_s1_r;
  logic dir_s2_r;
  logic rx_req_s1_r;
  logic rx_req_s2_r;
  logic rx_req_last_r;

  always_ff @(negedge ovh_clk_i) begin
    link_rst_s1_r <= reset_i;
    link_rst_r    <= link_rst_s1_r;
  end

  always_ff @(negedge ovh_clk_i) begin
    if (link_rst_r) begin
      en_s1_r     <= 1'b0;
      en_s2_r     <= 1'b0;
      dir_s1_r    <= 1'b0;
      dir_s2_r    <= 1'b0;
      rx_req_s1_r <= 1'b0;
      rx_req_s2_r <= 1'b0;
    end else begin
      en_s1_r     <= tx_enable_i;
      en_s2_r     <= en_s1_r;
      dir_s1_r    <= tx_path_dir_in_i;
      dir_s2_r    <= dir_s1_r;
      rx_req_s1_r <= rx_req_tgl_r;
      rx_req_s2_r <= rx_req_s1_r;
    end
  end

  assign rx_ovh_clk_out_o = ovh_clk_i;
  assign tx_ovh_clk_out_o = ovh_clk_i;

  // ---------------- extraction serializer, falling edge
  rx_state_t         rx_state_r;
  rx_state_t         rx_state_nxt;
  logic [BYTE_W-1:0] rx_sh_r;
  logic [BYTE_W-1:0] rx_sh_nxt;
  logic [2:0]        rx_bit_r;
  logic [2:0]        rx_bit_nxt;
  logic              rx_path_r;
  logic              rx_path_nxt;
  logic              rx_first_r;
  logic              rx_first_nxt;
  logic              rx_pend;
  logic              rx_load;

  assign rx_pend = rx_req_s2_r ^ rx_req_last_r;
  assign rx_load = rx_pend & ((rx_state_r == RX_IDLE) | (rx_bit_r == BIT_LAST));

  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_sh_nxt    = rx_sh_r;
    rx_bit_nxt   = rx_bit_r;
    rx_path_nxt  = rx_path_r;
    rx_first_nxt = rx_first_r;
    if (rx_load) begin
      rx_state_nxt = RX_SHIFT;
      rx_sh_nxt    = rx_hold_r[BYTE_W-1:0];
      rx_bit_nxt   = BIT_FIRST;
      rx_path_nxt  = rx_hold_r[RXW_PATH];
      rx_first_nxt = rx_hold_r[RXW_FIRST];
    end else begin
      case (rx_state_r)
        RX_SHIFT: begin
          if (rx_bit_r == BIT_LAST) begin
            rx_state_nxt = RX_IDLE;
          end else begin
            rx_bit_nxt = rx_bit_r + BIT_STEP;
            // [RULE17] msb shifts out first
            rx_sh_nxt  = {rx_sh_r[BYTE_W-2:0], 1'b0};
          end
        end
        RX_IDLE: begin
          rx_state_nxt = RX_IDLE;
        end
        default: begin
          rx_state_nxt = RX_IDLE;
        end
      endcase
    end
  end

  // [RULE1] outputs update on falling edge
  always_ff @(negedge ovh_clk_i) begin
    if (link_rst_r) begin
      rx_state_r           <= RX_IDLE;
      rx_sh_r              <= '0;
      rx_bit_r             <= BIT_FIRST;
      rx_path_r            <= 1'b0;
      rx_first_r           <= 1'b0;
      rx_req_last_r        <= 1'b0;
      rx_ack_tgl_r         <= 1'b0;
      rx_ovh_serial_out_o  <= 1'b0;
      rx_ovh_valid_flag_o  <= 1'b0;
      rx_ovh_frame_pulse_o <= 1'b0;
      rx_path_ovh_flag_o   <= 1'b0;
    end else begin
      rx_state_r  <= rx_state_nxt;
      rx_sh_r     <= rx_sh_nxt;
      rx_bit_r    <= rx_bit_nxt;
      rx_path_r   <= rx_path_nxt;
      rx_first_r  <= rx_first_nxt;
      if (rx_load) begin
        rx_req_last_r <= rx_req_s2_r;
        rx_ack_tgl_r  <= ~rx_ack_tgl_r;
      end
      rx_ovh_serial_out_o  <= rx_sh_nxt[BYTE_W-1];
      // [RULE5] valid only while shifting
      rx_ovh_valid_flag_o  <= (rx_state_nxt == RX_SHIFT);
      // [RULE3] [RULE4] pulse at first bit of a1/j1
      rx_ovh_frame_pulse_o <= (rx_state_nxt == RX_SHIFT) & rx_first_nxt
                              & (rx_bit_nxt == BIT_FIRST);
      // [RULE6] [RULE7] path flag follows byte kind
      rx_path_ovh_flag_o   <= rx_path_nxt;
    end
  end

  // ---------------- insertion timer, falling edge
  tx_state_t  tx_state_r;
  tx_state_t  tx_state_nxt;
  logic [2:0] tx_bit_r;
  logic [2:0] tx_bit_nxt;
  logic [7:0] tx_cnt_r;
  logic [7:0] tx_cnt_nxt;
  logic       tx_win_nxt;
  logic       tx_path_int_r;

  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_bit_nxt   = tx_bit_r + BIT_STEP;
    tx_cnt_nxt   = tx_cnt_r;
    case (tx_state_r)
      TX_SOH: begin
        if (tx_bit_r == BIT_LAST) begin
          tx_cnt_nxt = tx_cnt_r + CNT_STEP;
          if (tx_cnt_r == SOH_LAST) begin
            tx_state_nxt = TX_POH;
            tx_cnt_nxt   = CNT_ZERO;
          end
        end
      end
      TX_POH: begin
        if (tx_bit_r == BIT_LAST) begin
          tx_cnt_nxt = tx_cnt_r + CNT_STEP;
          if (tx_cnt_r == POH_LAST) begin
            tx_state_nxt = TX_GAP;
            tx_cnt_nxt   = CNT_ZERO;
          end
        end
      end
      TX_GAP: begin
        tx_bit_nxt = BIT_FIRST;
        if (tx_cnt_r < GAP_LAST) begin
          tx_cnt_nxt = tx_cnt_r + CNT_STEP;
        end else if (en_s2_r) begin
          tx_state_nxt = TX_SOH;
          tx_cnt_nxt   = CNT_ZERO;
        end
      end
      default: begin
        tx_state_nxt = TX_GAP;
        tx_bit_nxt   = BIT_FIRST;
        tx_cnt_nxt   = CNT_ZERO;
      end
    endcase
  end

  assign tx_win_nxt = (tx_state_nxt != TX_GAP);

  // [RULE14] path flag driven on falling edge
  always_ff @(negedge ovh_clk_i) begin
    if (link_rst_r) begin
      tx_state_r             <= TX_GAP;
      tx_bit_r               <= BIT_FIRST;
      tx_cnt_r               <= CNT_ZERO;
      tx_ovh_window_enable_o <= 1'b0;
      tx_ovh_frame_pulse_o   <= 1'b0;
      tx_path_int_r          <= 1'b0;
      tx_path_ovh_flag_oe_o  <= 1'b0;
    end else begin
      tx_state_r             <= tx_state_nxt;
      tx_bit_r               <= tx_bit_nxt;
      tx_cnt_r               <= tx_cnt_nxt;
      // [RULE8] window open over soh and poh
      tx_ovh_window_enable_o <= tx_win_nxt;
      // [RULE11] [RULE12] pulse at first a1/j1 bit
      tx_ovh_frame_pulse_o   <= tx_win_nxt & (tx_cnt_nxt == CNT_ZERO)
                                & (tx_bit_nxt == BIT_FIRST);
      tx_path_int_r          <= (tx_state_nxt == TX_POH);
      // [RULE15] drive released when configured as input
      tx_path_ovh_flag_oe_o  <= ~dir_s2_r;
    end
  end

  assign tx_path_ovh_flag_o = tx_path_int_r;

  // ---------------- insertion sampler, rising edge
  logic [BYTE_W-1:0] tx_dsh_r;
  logic [BYTE_W-1:0] tx_msk_r;
  logic [BYTE_W-1:0] tx_dsh_nxt;
  logic [BYTE_W-1:0] tx_msk_nxt;
  logic              tx_first_cap_r;
  logic              tx_path_cap_r;
  logic              tx_path_now;
  logic [TXW_W-1:0]  tx_word_r;
  logic              tx_tgl_r;
  logic              tx_sample;

  assign tx_sample   = tx_ovh_window_enable_o;
  // [RULE15] external path flag when turned round
  assign tx_path_now = dir_s2_r ? tx_path_ovh_flag_i : tx_path_int_r;
  // [RULE16] [RULE17] uninserted bits masked, msb first
  assign tx_dsh_nxt  = {tx_dsh_r[BYTE_W-2:0], tx_ovh_serial_in_i & tx_ovh_insert_req_i};
  assign tx_msk_nxt  = {tx_msk_r[BYTE_W-2:0], tx_ovh_insert_req_i};

  // [RULE10] inputs sampled on rising edge
  always_ff @(posedge ovh_clk_i) begin
    if (link_rst_r) begin
      tx_dsh_r       <= '0;
      tx_msk_r       <= '0;
      tx_first_cap_r <= 1'b0;
      tx_path_cap_r  <= 1'b0;
      tx_word_r      <= '0;
      tx_tgl_r       <= 1'b0;
    end else if (tx_sample) begin
      tx_dsh_r <= tx_dsh_nxt;
      tx_msk_r <= tx_msk_nxt;
      if (tx_bit_r == BIT_FIRST) begin
        tx_first_cap_r <= tx_ovh_frame_pulse_o;
        tx_path_cap_r  <= tx_path_now;
      end
      if (tx_bit_r == BIT_LAST) begin
        tx_word_r <= {tx_first_cap_r, tx_path_cap_r, tx_msk_nxt, tx_dsh_nxt};
        tx_tgl_r  <= ~tx_tgl_r;
      end
    end
  end

  // ---------------- reference domain: insertion result
  logic tx_tgl_s1_r;
  logic tx_tgl_s2_r;
  logic tx_tgl_last_r;
  logic tx_new;
  logic [BYTE_W-1:0] tx_in_data;
  logic [BYTE_W-1:0] tx_in_mask;

  assign tx_new     = tx_tgl_s2_r ^ tx_tgl_last_r;
  assign tx_in_data = tx_word_r[BYTE_W-1:0];
  assign tx_in_mask = tx_word_r[TXW_MASK_LO +: BYTE_W];

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_tgl_s1_r     <= 1'b0;
      tx_tgl_s2_r     <= 1'b0;
      tx_tgl_last_r   <= 1'b0;
      tx_byte_o       <= '0;
      tx_byte_mask_o  <= '0;
      tx_byte_path_o  <= 1'b0;
      tx_byte_first_o <= 1'b0;
      tx_byte_valid_o <= 1'b0;
    end else begin
      tx_tgl_s1_r     <= tx_tgl_r;
      tx_tgl_s2_r     <= tx_tgl_s1_r;
      tx_tgl_last_r   <= tx_tgl_s2_r;
      tx_byte_valid_o <= tx_new;
      if (tx_new) begin
        // [RULE16] default value where not inserted
        tx_byte_o       <= (tx_in_data & tx_in_mask) | (tx_default_byte_i & ~tx_in_mask);
        tx_byte_mask_o  <= tx_in_mask;
        tx_byte_path_o  <= tx_word_r[TXW_PATH];
        tx_byte_first_o <= tx_word_r[TXW_FIRST];
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/ovh_port_checker.sv
// link-domain assertions for the serial overhead port
`timescale 1ns/1ns
`default_nettype none
module ovh_port_checker
  import ovh_port_pkg::*;
#(
  parameter int SOH_BYTES = 2,
  parameter int POH_BYTES = 2
) (
  input wire logic reset_i,
  input wire logic ovh_clk_i,
  input wire logic rx_ovh_serial_out_o,
  input wire logic rx_ovh_frame_pulse_o,
  input wire logic rx_ovh_valid_flag_o,
  input wire logic rx_path_ovh_flag_o,
  input wire logic tx_path_dir_in_i,
  input wire logic tx_ovh_window_enable_o,
  input wire logic tx_ovh_frame_pulse_o,
  input wire logic tx_path_ovh_flag_o,
  input wire logic tx_path_ovh_flag_oe_o
);
  localparam int S8 = SOH_BYTES * 8;
  localparam int T8 = (SOH_BYTES + POH_BYTES) * 8;
  wire logic [3:0] rx_v = {rx_ovh_serial_out_o, rx_ovh_frame_pulse_o,
                           rx_ovh_valid_flag_o, rx_path_ovh_flag_o};
  wire logic [3:0] tx_v = {tx_ovh_window_enable_o, tx_ovh_frame_pulse_o,
                           tx_path_ovh_flag_o, tx_path_ovh_flag_oe_o};
  logic [7:0] snap_r;
  logic [2:0] bit_r;
  int         cnt_r;
  // pin values seen at the rising edge
  always_ff @(posedge ovh_clk_i) snap_r <= {rx_v, tx_v};
  // bit index of the extraction byte and of the window
  always_ff @(negedge ovh_clk_i) begin
    bit_r <= (reset_i || !rx_ovh_valid_flag_o) ? 3'h0 : bit_r + 3'h1;
    cnt_r <= (reset_i || !tx_ovh_window_enable_o) ? 0 : cnt_r + 1;
  end
  default clocking cb @(negedge ovh_clk_i); endclocking
  default disable iff (reset_i);
  chk_rx_edge: assert property (rx_v == snap_r[7:4])
    else $error("extraction pin moved while link clock high");
  chk_rx_frame_pos: assert property (rx_ovh_frame_pulse_o |->
    rx_ovh_valid_flag_o && bit_r == 3'h0) else $error("extraction frame pulse off bit 0");
  chk_rx_path_hold: assert property (rx_ovh_valid_flag_o && bit_r != 3'h0
    |-> $stable(rx_path_ovh_flag_o)) else $error("extraction path flag moved in byte");
  chk_rx_valid_end: assert property ($fell(rx_ovh_valid_flag_o) |-> bit_r == 3'h0)
    else $error("extraction valid dropped mid byte");
  chk_tx_edge: assert property (tx_v == snap_r[3:0])
    else $error("insertion pin moved while link clock high");
  chk_tx_frame_pos: assert property (tx_ovh_frame_pulse_o ==
    (tx_ovh_window_enable_o && (cnt_r == 0 || cnt_r == S8)))
    else $error("insertion frame pulse misplaced");
  chk_tx_frame_kind: assert property (tx_ovh_frame_pulse_o && tx_path_ovh_flag_oe_o
    |-> tx_path_ovh_flag_o == (cnt_r != 0)) else $error("insertion frame pulse wrong kind");
  chk_tx_path_kind: assert property (tx_ovh_window_enable_o && tx_path_ovh_flag_oe_o
    |-> tx_path_ovh_flag_o == (cnt_r >= S8)) else $error("insertion path flag wrong");
  chk_tx_window_len: assert property ($fell(tx_ovh_window_enable_o) |-> cnt_r == T8)
    else $error("insertion window wrong length");
  chk_tx_oe_input: assert property (tx_path_dir_in_i [*4] |-> !tx_path_ovh_flag_oe_o)
    else $error("path flag driven in input mode");
endmodule
bind ovh_serial_port ovh_port_checker #(.SOH_BYTES(SOH_BYTES), .POH_BYTES(POH_BYTES)) chk_u (
  .reset_i(reset_i), .ovh_clk_i(ovh_clk_i), .rx_ovh_serial_out_o(rx_ovh_serial_out_o),
  .rx_ovh_frame_pulse_o(rx_ovh_frame_pulse_o), .rx_ovh_valid_flag_o(rx_ovh_valid_flag_o),
  .rx_path_ovh_flag_o(rx_path_ovh_flag_o), .tx_path_dir_in_i(tx_path_dir_in_i),
  .tx_ovh_window_enable_o(tx_ovh_window_enable_o), .tx_ovh_frame_pulse_o(tx_ovh_frame_pulse_o),
  .tx_path_ovh_flag_o(tx_path_ovh_flag_o), .tx_path_ovh_flag_oe_o(tx_path_ovh_flag_oe_o));
`default_nettype wire

//--- verification/ovh_term_model.sv
// terminal equipment model at the overhead pins
`timescale 1ns/1ns
`default_nettype none
module ovh_term_model #(
  parameter int          SOH_BYTES = 2,
  parameter logic [31:0] SEED      = 32'h1
) (
  input  wire logic rx_clk_i,
  input  wire logic rx_data_i,
  input  wire logic rx_frame_i,
  input  wire logic rx_valid_i,
  input  wire logic rx_path_i,
  input  wire logic tx_clk_i,
  input  wire logic tx_window_i,
  output var  logic tx_data_o,
  output var  logic tx_insert_o,
  output var  logic tx_path_o
);
  logic [9:0]  rx_q[$];
  logic [17:0] tx_q[$];
  logic [31:0] st = SEED;
  logic [7:0]  sr, cd, cm;
  logic        f, p, tf, tp;
  int          k = 0;
  int          n = 0;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  initial begin
    tx_data_o = 1'b0;
    tx_insert_o = 1'b0;
    tx_path_o = 1'b0;
  end
  // sample, frame and kind at bit 0
  always @(posedge rx_clk_i) begin
    if (rx_valid_i === 1'b1) begin
      if (k == 0) begin
        f = rx_frame_i;
        p = rx_path_i;
      end
      sr = {sr[6:0], rx_data_i};
      k = k + 1;
      if (k == 8) begin
        rx_q.push_back({f, p, sr});
        k = 0;
      end
    end else k = 0;
  end
  // drive after falling edge, msb first
  always @(negedge tx_clk_i) begin
    #1;
    st = xs(st);
    if (tx_window_i === 1'b1) begin
      if (n % 8 == 0) begin
        {cm, cd} = st[15:0];
        tf = (n == 0) || (n == SOH_BYTES * 8);
        tp = n >= SOH_BYTES * 8;
      end
      tx_data_o = cd[7 - n % 8];
      tx_insert_o = cm[7 - n % 8];
      tx_path_o = tp;
      if (n % 8 == 7) tx_q.push_back({tf, tp, cm, cd});
      n = n + 1;
    end else begin
      n = 0;
      tx_data_o = ~tx_data_o;
      tx_insert_o = st[0];
      tx_path_o = ~tx_path_o;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_ovh_serial_port.sv
// testbench for the serial overhead port
`timescale 1ns/1ns
`default_nettype none
`define check_eq(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end
module tb_ovh_serial_port;
  import ovh_port_pkg::*;
  localparam int SOH = 2;
  logic        clk = 1'b0, lclk = 1'b0, rst = 1'b1, saw_full = 1'b0;
  logic        rx_p = 1'b0, rx_f = 1'b0, rx_v = 1'b0, en = 1'b0, dir = 1'b0;
  logic [7:0]  rx_b = 8'h00, def_b = 8'hA5, exp_b;
  logic [9:0]  exp_rx[$];
  logic [9:0]  got_rx, exp_w;
  logic [17:0] got_tx;
  logic [31:0] st = 32'h88658F35;
  int          mismatches = 0, tests_run = 0, cyc = 0, tx_seen = 0, n0;
  wire logic   rdy, r_clk, r_d, r_fr, r_val, r_pa, t_clk, t_win, t_fr, t_po, t_oe;
  wire logic   b_val, b_pa, b_fi, m_d, m_ins, m_pa;
  wire logic [7:0] b_byte, b_mask;
  wire logic   t_pw = t_oe ? t_po : m_pa;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  ovh_serial_port #(.SOH_BYTES(SOH), .POH_BYTES(2), .GAP_BITS(4)) dut_u (
    .ref_clk_i(clk), .reset_i(rst), .ovh_clk_i(lclk), .rx_byte_i(rx_b), .rx_byte_path_i(rx_p),
    .rx_byte_first_i(rx_f), .rx_byte_valid_i(rx_v), .rx_byte_ready_o(rdy),
    .rx_ovh_clk_out_o(r_clk), .rx_ovh_serial_out_o(r_d), .rx_ovh_frame_pulse_o(r_fr),
    .rx_ovh_valid_flag_o(r_val), .rx_path_ovh_flag_o(r_pa), .tx_enable_i(en),
    .tx_path_dir_in_i(dir), .tx_default_byte_i(def_b), .tx_byte_o(b_byte),
    .tx_byte_mask_o(b_mask), .tx_byte_path_o(b_pa), .tx_byte_first_o(b_fi),
    .tx_byte_valid_o(b_val), .tx_ovh_clk_out_o(t_clk), .tx_ovh_window_enable_o(t_win),
    .tx_ovh_serial_in_i(m_d), .tx_ovh_insert_req_i(m_ins), .tx_ovh_frame_pulse_o(t_fr),
    .tx_path_ovh_flag_i(t_pw), .tx_path_ovh_flag_o(t_po), .tx_path_ovh_flag_oe_o(t_oe));
  ovh_term_model #(.SOH_BYTES(SOH), .SEED(32'h88658F35)) p_u (
    .rx_clk_i(r_clk), .rx_data_i(r_d), .rx_frame_i(r_fr), .rx_valid_i(r_val),
    .rx_path_i(r_pa), .tx_clk_i(t_clk), .tx_window_i(t_win), .tx_data_o(m_d),
    .tx_insert_o(m_ins), .tx_path_o(m_pa));
  always #25 clk = ~clk;
  initial begin
    #7;
    forever #40 lclk = ~lclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      finish_test();
    end
  end
  always @(negedge clk) begin
    if (p_u.rx_q.size() != 0) begin
      got_rx = p_u.rx_q.pop_front();
      `check_eq(exp_rx.size() != 0, 1'b1)
      if (exp_rx.size() != 0) begin
        exp_w = exp_rx.pop_front();
        `check_eq(got_rx, exp_w)
      end
    end
    if (b_val === 1'b1) begin
      tx_seen++;
      `check_eq(p_u.tx_q.size() != 0, 1'b1)
      if (p_u.tx_q.size() != 0) begin
        got_tx = p_u.tx_q.pop_front();
        exp_b = (got_tx[7:0] & got_tx[15:8]) | (def_b & ~got_tx[15:8]);
        `check_eq(b_byte, exp_b)
        `check_eq(b_mask, got_tx[15:8])
        `check_eq({b_fi, b_pa}, got_tx[17:16])
      end
    end
  end
  task automatic push_word(input logic [9:0] w);
    @(negedge clk);
    {rx_f, rx_p, rx_b} = w;
    rx_v = 1'b1;
    while (rdy !== 1'b1) begin
      saw_full = 1'b1;
      @(negedge clk);
    end
    exp_rx.push_back(w);
  endtask
  task automatic wait_drain();
    repeat (3000) begin
      if (exp_rx.size() == 0) break;
      @(negedge clk);
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    en = 1'b1;
    for (int i = 0; i < 24; i++) begin
      st = xs(st);
      push_word({i % 6 == 0, i % 12 >= 6, st[7:0]});
    end
    @(negedge clk);
    rx_v = 1'b0;
    wait_drain();
    `check_eq(saw_full, 1'b1)
    $display("test rx_burst done");
    for (int i = 0; i < 3; i++) begin
      st = xs(st);
      push_word({i != 0, i == 2, st[7:0]});
      @(negedge clk);
      rx_v = 1'b0;
      repeat (40) @(negedge clk);
    end
    wait_drain();
    $display("test rx_single done");
    @(posedge clk iff b_val === 1'b1);
    @(negedge clk);
    st = xs(st);
    def_b = st[7:0];
    dir = 1'b1;
    n0 = tx_seen;
    wait (tx_seen >= n0 + 8);
    $display("test tx_path_input done");
    @(negedge clk);
    en = 1'b0;
    repeat (200) @(negedge clk);
    n0 = tx_seen;
    repeat (200) @(negedge clk);
    `check_eq(t_win, 1'b0)
    `check_eq(tx_seen == n0 && p_u.tx_q.size() == 0, 1'b1)
    $display("test tx_stop done");
    finish_test();
  end
endmodule
`default_nettype wire
